// [rtl/odsp_defines.svh]
`ifndef ODSP_DEFINES_SVH
`define ODSP_DEFINES_SVH
// frame layout, msb first, two leading bits ignored
`define ODSP_FRAME_BITS 16
`define ODSP_ADDR_MSB 13
`define ODSP_ADDR_LSB 11
`define ODSP_CTRL_MSB 10
`define ODSP_CTRL_LSB 8
`define ODSP_DATA_MSB 7
`define ODSP_DATA_LSB 0
// control codes
`define ODSP_CMD_NOP 3'h0
`define ODSP_CMD_CLEAR 3'h1
`define ODSP_CMD_SHDN 3'h2
`define ODSP_CMD_PHASE 3'h3
`define ODSP_CMD_LOAD_ALL 3'h4
`define ODSP_CMD_LOAD_IN 3'h5
`define ODSP_CMD_LOAD_UPD 3'h6
`define ODSP_CMD_SW_LOAD 3'h7
// reset values
`define ODSP_RST_CODE 8'h00
`define ODSP_RST_PHASE 1'b0
`define ODSP_RST_SHIFT 16'h0000
`define ODSP_RST_MASK 8'hff
// strobe minimum width, ns, and clk_sys cycles at 5 ns (rounded up)
`define ODSP_STROBE_MIN_NS 40
`define ODSP_CLK_NS 5
`define ODSP_STROBE_MIN_CYC ((`ODSP_STROBE_MIN_NS + `ODSP_CLK_NS - 1) / `ODSP_CLK_NS)
`endif

// [rtl/odsp_pkg.sv]
package odsp_pkg;
  typedef logic [7:0] odsp_code_t;
  typedef logic [2:0] odsp_cmd_t;
  typedef logic [63:0] odsp_bank_t;
endpackage : odsp_pkg

// [rtl/odsp_sync.sv]
`timescale 1ns/10ps
// three-stage synchroniser for one pin, with settled level and edges
module odsp_sync #(
  // reset level matches the pin's idle level, so no false edge follows reset
  parameter logic IDLE = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pin side
  input wire logic pin,
  // settled level and edges
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_r; // metastability catcher, read only by s2_r
  logic s2_r;
  logic s3_r;
  logic lvl_r; // last agreed level

  // shift pin through three flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_r <= IDLE;
      s2_r <= IDLE;
      s3_r <= IDLE;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  wire agree = (s2_r == s3_r); // stages two and three agree
  wire changed = agree && (s3_r != lvl_r);

  // settle the level once two and three agree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lvl_r <= IDLE;
    end else if (agree) begin
      lvl_r <= s3_r;
    end
  end

  assign level = lvl_r;
  assign rise = changed && s3_r;
  assign fall = changed && !s3_r;
endmodule : odsp_sync

// [rtl/odsp_port.sv]
`timescale 1ns/10ps
`include "odsp_defines.svh"
module odsp_port
  import odsp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  // asynchronous load pin
  input wire logic load_strobe_n,
  // channel codes, channel 0 in low byte
  output odsp_pkg::odsp_bank_t dac_codes,
  output odsp_pkg::odsp_bank_t input_codes,
  // status
  output logic phase_mode,
  output logic [7:0] shutdown_mask
);
  import odsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic sclk_rise, sclk_fall;
  logic cs_lvl, cs_rise;
  logic din_lvl, ld_lvl;

  odsp_sync #(.IDLE(1'b0)) u_sync_sclk (.clk_sys(clk_sys), .rst(rst), .pin(sclk),
    .level(), .rise(sclk_rise), .fall(sclk_fall));
  odsp_sync #(.IDLE(1'b1)) u_sync_cs (.clk_sys(clk_sys), .rst(rst), .pin(cs_n),
    .level(cs_lvl), .rise(cs_rise), .fall());
  odsp_sync #(.IDLE(1'b0)) u_sync_din (.clk_sys(clk_sys), .rst(rst), .pin(din),
    .level(din_lvl), .rise(), .fall());
  odsp_sync #(.IDLE(1'b1)) u_sync_ld (.clk_sys(clk_sys), .rst(rst), .pin(load_strobe_n),
    .level(ld_lvl), .rise(), .fall());

  ////////////////////////////////////////////////////////////////////////
  // shift register
  logic [15:0] shift_r; // last sixteen bits taken
  logic dout_r; // serial output
  logic phase_r; // launch edge select
  logic cs_low_r; // select low, tracked from settled level

  // active frame: select settled low
  wire frame_on = !cs_lvl;
  wire shift_en = frame_on && sclk_rise;
  wire launch_edge = phase_r ? sclk_rise : sclk_fall;
  wire launch_en = frame_on && launch_edge;

  // din is settled a cycle before the rising edge flag, so sampling is aligned
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_r <= `ODSP_RST_SHIFT;
    end else if (shift_en) begin
      shift_r <= {shift_r[14:0], din_lvl};
    end
  end

  // msb leaves sixteen clocks after entry; in rising mode take it before the shift
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dout_r <= 1'b0;
    end else if (launch_en) begin
      dout_r <= shift_r[15];
    end
  end
  assign dout = dout_r; // always driven

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cs_low_r <= 1'b0;
    end else begin
      cs_low_r <= frame_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command decode at select rising
  wire exec = cs_rise;
  wire [2:0] f_addr = shift_r[`ODSP_ADDR_MSB:`ODSP_ADDR_LSB];
  odsp_cmd_t f_ctrl;
  assign f_ctrl = shift_r[`ODSP_CTRL_MSB:`ODSP_CTRL_LSB];
  odsp_code_t f_data;
  assign f_data = shift_r[`ODSP_DATA_MSB:`ODSP_DATA_LSB];
  wire do_clear = exec && (f_ctrl == `ODSP_CMD_CLEAR);
  wire do_all = exec && (f_ctrl == `ODSP_CMD_LOAD_ALL);
  wire do_in = exec && (f_ctrl == `ODSP_CMD_LOAD_IN);
  wire do_upd = exec && (f_ctrl == `ODSP_CMD_LOAD_UPD);
  wire do_copy = exec && ((f_ctrl == `ODSP_CMD_SW_LOAD) ||
                          (f_ctrl == `ODSP_CMD_PHASE));
  wire do_phase = exec && (f_ctrl == `ODSP_CMD_PHASE);
  wire do_shdn = exec && (f_ctrl == `ODSP_CMD_SHDN);
  wire strobe_copy = !ld_lvl; // level-sensitive copy
  wire wake = do_clear || do_all || do_in || do_upd;

  // phase select
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_r <= `ODSP_RST_PHASE;
    end else if (do_phase) begin
      phase_r <= f_addr[2];
    end
  end
  assign phase_mode = phase_r;

  // shutdown mask, all enabled after reset
  logic [7:0] shdn_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shdn_r <= `ODSP_RST_MASK;
    end else if (do_shdn) begin
      shdn_r <= f_data;
    end else if (wake) begin
      shdn_r <= `ODSP_RST_MASK;
    end
  end
  assign shutdown_mask = shdn_r;

  ////////////////////////////////////////////////////////////////////////
  // per-channel input and output registers
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch++) begin : g_ch
      odsp_code_t in_r;
      odsp_code_t out_r;
      wire hit = (f_addr == 3'(ch));
      wire ld_in = do_all || ((do_in || do_upd) && hit);
      odsp_code_t in_nxt;
      assign in_nxt = do_clear ? `ODSP_RST_CODE : (ld_in ? f_data : in_r);
      // input register; code 000 leaves it alone
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          in_r <= `ODSP_RST_CODE;
        end else begin
          in_r <= in_nxt;
        end
      end
      // output register; load-all updates outputs too
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          out_r <= `ODSP_RST_CODE;
        end else if (do_clear) begin
          out_r <= `ODSP_RST_CODE;
        end else if (do_all || (do_upd && hit)) begin
          out_r <= f_data;
        end else if (do_copy || strobe_copy) begin
          out_r <= in_r;
        end
      end
      assign input_codes[ch*8 +: 8] = in_r;
      assign dac_codes[ch*8 +: 8] = out_r;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_nop_holds: assert property (@(posedge clk_sys) disable iff (rst)
    (exec && f_ctrl == `ODSP_CMD_NOP && ld_lvl) |=> $stable(input_codes))
    else $error("nop changed an input register");
  chk_no_exec_low: assert property (@(posedge clk_sys) disable iff (rst)
    (frame_on && !exec) |=> $stable(input_codes))
    else $error("input register changed while select low");
  chk_idle_dout: assert property (@(posedge clk_sys) disable iff (rst)
    (!frame_on && cs_low_r == 1'b0) |=> $stable(dout))
    else $error("output moved while select high");
  chk_shift_in: assert property (@(posedge clk_sys) disable iff (rst)
    shift_en |=> (shift_r[0] == $past(din_lvl)))
    else $error("shift register missed sampled bit");
  chk_idle_shift: assert property (@(posedge clk_sys) disable iff (rst)
    !frame_on |=> $stable(shift_r))
    else $error("shift register moved while select high");
  chk_dout_msb: assert property (@(posedge clk_sys) disable iff (rst)
    launch_en |=> (dout == $past(shift_r[15])))
    else $error("output not taken from last stage");
  chk_launch_edge: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(dout) |-> $past(frame_on && (phase_r ? sclk_rise : sclk_fall)))
    else $error("output changed on wrong edge");
  chk_strobe_copy: assert property (@(posedge clk_sys) disable iff (rst)
    (strobe_copy && !exec) |=> (dac_codes == $past(input_codes)))
    else $error("strobe did not copy inputs");
  chk_clear_all: assert property (@(posedge clk_sys) disable iff (rst)
    do_clear |=> (input_codes == 64'h0 && dac_codes == 64'h0))
    else $error("clear left a register set");
  chk_phase_set: assert property (@(posedge clk_sys) disable iff (rst)
    do_phase |=> (phase_r == $past(f_addr[2])))
    else $error("phase not taken from address bit");
  chk_sw_copy: assert property (@(posedge clk_sys) disable iff (rst)
    (exec && f_ctrl == `ODSP_CMD_SW_LOAD) |=> (dac_codes == $past(input_codes)))
    else $error("copy command missed a channel");
  // clear, load-all, load-input and load-update commands bring every channel out of shutdown
  chk_mask_wake: assert property (@(posedge clk_sys) disable iff (rst)
    wake |=> (shutdown_mask == `ODSP_RST_MASK))
    else $error("load command left channels shut down");
  cov_frame_exec: cover property (@(posedge clk_sys) disable iff (rst) do_upd);
  cov_phase_one: cover property (@(posedge clk_sys) disable iff (rst) do_phase && f_addr[2]);
  cov_strobe: cover property (@(posedge clk_sys) disable iff (rst) strobe_copy);
  cov_load_all: cover property (@(posedge clk_sys) disable iff (rst) do_all);
endmodule : odsp_port

// [dv/odsp_host_model.sv]
`timescale 1ns/10ps
// host side of the link: frames words onto the pins
module odsp_host_model (
  // clock
  input wire logic clk_sys,
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  int pace = 1; // clock stretch factor; 4 keeps the link under 4 MHz
  // idle: select high, clock parked low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // one frame, msb first, optionally 4+4+8 packets; returns dout bits
  task automatic send(input logic [15:0] w, input bit split, output logic [15:0] got);
    @(negedge clk_sys) cs_n = 1'b0;
    repeat (10) @(negedge clk_sys);
    // sixteen pulses, header before data
    for (int i = 15; i >= 0; i--) begin
      if (split && (i == 11 || i == 7)) repeat (30) @(negedge clk_sys);
      din = w[i];
      repeat (5 * pace) @(negedge clk_sys);
      sclk = 1'b1;
      repeat (8 * pace) @(negedge clk_sys);
      got[i] = dout;
      sclk = 1'b0;
    end
    repeat (5) @(negedge clk_sys);
    cs_n = 1'b1;
    din = ~din; // stale data is not held
    repeat (24) @(negedge clk_sys);
  endtask : send
  // clock pulses with select high, data changing
  task automatic stray(input int n);
    repeat (n) begin
      din = ~din;
      sclk = 1'b1;
      repeat (7) @(negedge clk_sys);
      sclk = 1'b0;
      repeat (7) @(negedge clk_sys);
    end
  endtask : stray
endmodule : odsp_host_model

// [dv/test_octal_dac_serial_port.sv]
`timescale 1ns/10ps
module test_octal_dac_serial_port;
  import odsp_pkg::*;
  // design pins
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic load_strobe_n = 1'b1;
  wire logic sclk, cs_n, din, dout;
  odsp_bank_t dac_codes, input_codes;
  logic phase_mode;
  logic [7:0] shutdown_mask;
  // expected state
  odsp_bank_t ein, edac;
  logic eph, resync, hold;
  logic [15:0] got, prev;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  // one word and the shutdown mask it should leave per row, every control code
  logic [23:0] rows [13] = '{24'hc512ff, 24'h3da5ff, 24'h3e5aff, 24'h07ffff, 24'h9c3cff,
    24'h1577ff, 24'h78ffff, 24'h020f0f, 24'h23000f, 24'h1ec3ff, 24'h01aaff, 24'h0300ff,
    24'h0512ff};
  always #2.5 clk_sys = ~clk_sys;
  odsp_port i_odsp_port (.clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .load_strobe_n(load_strobe_n), .dac_codes(dac_codes),
    .input_codes(input_codes), .phase_mode(phase_mode), .shutdown_mask(shutdown_mask));
  odsp_host_model i_odsp_host_model (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout));
  ////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
    checks++;
    if (seen !== exp)
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    if (seen !== exp)
      fail_count++;
  endtask : chk
  // reference effect of one command
  task automatic apply(input logic [15:0] w);
    case (w[10:8])
      3'h1: begin
        ein = '0;
        edac = '0;
      end
      3'h3: begin
        resync = eph & ~w[13];
        eph = w[13];
        edac = ein;
      end
      3'h4: begin
        ein = {8{w[7:0]}};
        edac = ein;
      end
      3'h5: ein[w[13:11]*8+:8] = w[7:0];
      3'h6: begin
        ein[w[13:11]*8+:8] = w[7:0];
        edac[w[13:11]*8+:8] = w[7:0];
      end
      3'h7: edac = ein;
      default: ;
    endcase
  endtask : apply
  // send one word, check the pass-through and the registers
  task automatic frame(input logic [15:0] w, input bit split, input logic [7:0] emask);
    i_odsp_host_model.send(w, split, got);
    if (!resync) chk("dout word", prev, got);
    resync = 1'b0;
    prev = w;
    apply(w);
    chk("input codes", ein, input_codes);
    chk("dac codes", edac, dac_codes);
    chk("phase", eph, phase_mode);
    chk("mask", emask, shutdown_mask);
  endtask : frame
  task automatic do_reset(input int n);
    @(negedge clk_sys) rst = 1'b1;
    repeat (n) @(negedge clk_sys);
    rst = 1'b0;
    repeat (5) @(negedge clk_sys);
    {ein, edac, eph, resync, prev} = '0;
    chk("input codes", ein, input_codes);
    chk("dac codes", edac, dac_codes);
    chk("phase", eph, phase_mode);
    chk("mask", 8'hff, shutdown_mask);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////
  initial begin
    do_reset(20);
    foreach (rows[i]) frame(rows[i][23:8], 1'b0, rows[i][7:0]);
    // split packets, input only
    frame(16'h0d99, 1'b1, 8'hff);
    // strobe copies inputs to outputs
    load_strobe_n = 1'b0;
    repeat (10) @(negedge clk_sys);
    edac = ein;
    chk("strobe dac", edac, dac_codes);
    load_strobe_n = 1'b1;
    // clock with select high is ignored
    hold = dout;
    i_odsp_host_model.stray(4);
    chk("idle dout", hold, dout);
    chk("idle inputs", ein, input_codes);
    i_odsp_host_model.pace = 4;
    frame(16'h78ff, 1'b0, 8'hff);
    i_odsp_host_model.pace = 1;
    // reset in mid-run from phase mode one
    frame(16'h2300, 1'b0, 8'hff);
    do_reset(3);
    frame(16'h0512, 1'b0, 8'hff);
    close_out();
  end
endmodule : test_octal_dac_serial_port
